// ---- dv/coproc_register_transfer_primitives_bench.sv ----
`timescale 1ns/1ps
module coproc_register_transfer_primitives_bench;
  logic               ref_clk, sys_rst, prim_valid, cond_category, instr_start, cop_done;
  logic [15:0]        prim_word, status_word;
  logic               ea_req, ea_done = 1'b0, scan_pc_load, slow;
  crt_pkg::crt_ea_e   ea_mode;
  logic [31:0]        ea_addr, port_wdata, port_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [2:0]         ea_ext_words, ea_areg;
  logic               port_req, port_wr, port_ack, mem_req, mem_wr, mem_ack, rf_we, cr_we;
  crt_pkg::crt_port_e port_sel;
  logic [3:0]         rf_idx;
  logic [11:0]        cr_sel;
  logic [31:0]        rf_wdata, rf_rdata, cr_wdata, cr_rdata, scan_program_counter;
  logic [31:0]        scan_pc_init, sel_data, op_data, cr_seen;
  logic               pipe_flush, pipe_refill_super, proto_violation, fline_exception;
  logic               trace_exception, busy;
  int                 bad_count, checked, pv_n, fl_n, pf_n, pv_d, fl_d, pf_d, tr_n;
  logic [7:0]         rf_log;
  logic [31:0]        rf_dat, mem_last;

  crt_core crt_core_i (.ref_clk, .sys_rst, .prim_valid, .prim_word, .cond_category,
    .instr_start, .cop_done, .ea_req, .ea_done, .ea_mode, .ea_addr, .ea_ext_words, .ea_areg,
    .port_req, .port_wr, .port_sel, .port_wdata, .port_ack, .port_rdata, .mem_req, .mem_wr,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .rf_we, .rf_idx, .rf_wdata, .rf_rdata,
    .cr_we, .cr_sel, .cr_wdata, .cr_rdata, .status_word, .scan_program_counter,
    .scan_pc_init, .scan_pc_load, .pipe_flush, .pipe_refill_super, .proto_violation,
    .fline_exception, .trace_exception, .busy);
  crt_cop_model crt_cop_model_i (.ref_clk, .sys_rst, .slow, .sel_data, .op_data, .port_req,
    .port_wr, .port_sel, .port_wdata, .port_ack, .port_rdata, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);

  // ---------------------------------------------------------------------------
  // Responders and monitors
  // ---------------------------------------------------------------------------
  // Register files return values that encode the index, so order is visible.
  assign rf_rdata = {16'hD0D0, 12'h000, rf_idx};
  assign cr_rdata = {20'h0_C5C5, cr_sel};

  // Address unit finishes one cycle after each request; pulses are counted.
  always @(posedge ref_clk) begin
    ea_done <= ea_req && !ea_done;
    if (cr_we) cr_seen <= cr_wdata;
    if (proto_violation) pv_n++;
    if (fline_exception) fl_n++;
    if (pipe_flush) pf_n++;
    if (trace_exception) tr_n++;
    if (rf_we) rf_log <= {rf_log[3:0], rf_idx};
    if (rf_we) rf_dat <= rf_wdata;
    if (mem_ack) mem_last <= mem_addr;
  end

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task cmp(input string nm, input logic [34:0] exp, input logic [34:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [34:0] logent(input int i);
    return (i < crt_cop_model_i.log_q.size()) ? crt_cop_model_i.log_q[i] : 35'bx;
  endfunction

  task cmp_log(input int i, input logic wr, input crt_pkg::crt_port_e s, input logic [31:0] d);
    cmp("port log", {wr, s, d}, logent(i));
  endtask

  function automatic logic [15:0] prim(input logic ca, dr, input logic [4:0] p, input logic [7:0] l);
    return {ca, 1'b0, dr, p, l};
  endfunction

  // Issues one primitive, waits for idle and reports pulse counts seen meanwhile.
  task run(input logic [15:0] w, input logic cond, input logic sl);
    int n;
    int p0, f0, q0;
    p0 = pv_n;
    f0 = fl_n;
    q0 = pf_n;
    crt_cop_model_i.log_q.delete();
    @(posedge ref_clk);
    prim_word <= w;
    cond_category <= cond;
    slow <= sl;
    prim_valid <= 1'b1;
    @(posedge ref_clk);
    prim_valid <= 1'b0;
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge ref_clk);
    if (n >= 300) cmp("busy", 35'h0, 35'h1);
    pv_d = pv_n - p0;
    fl_d = fl_n - f0;
    pf_d = pf_n - q0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_ctrl_bad;
    sel_data <= 32'h0000_0805;
    run(prim(1'b1, 1'b0, crt_pkg::PAT_CTRL_REG, 8'h00), 1'b0, 1'b0);
    cmp("violation", 35'h1, pv_d);
    cmp("log size", 35'h1, crt_cop_model_i.log_q.size());
    cmp_log(0, 1'b0, crt_pkg::CRT_PORT_SELECT, 32'h0000_0000);
  endtask

  task t_ctrl(input logic dr);
    sel_data <= {20'h0_000F, crt_pkg::SEL_VEC_BASE};
    op_data <= 32'h1234_5678;
    run(prim(1'b1, dr, crt_pkg::PAT_CTRL_REG, 8'h00), 1'b0, 1'b1);
    cmp("violation", 35'h0, pv_d);
    cmp_log(0, 1'b0, crt_pkg::CRT_PORT_SELECT, 32'h0000_0000);
    if (dr) begin
      cmp_log(1, 1'b0, crt_pkg::CRT_PORT_OPERAND, 32'h0000_0000);
      cmp("ctrl load", op_data, cr_seen);
    end else begin
      cmp_log(1, 1'b1, crt_pkg::CRT_PORT_OPERAND, {20'h0_C5C5, crt_pkg::SEL_VEC_BASE});
    end
  endtask

  task t_main;
    sel_data <= 32'h0000_8001;
    run(prim(1'b1, 1'b0, crt_pkg::PAT_MULTI_MAIN, 8'h00), 1'b1, 1'b0);
    cmp("log size", 35'h3, crt_cop_model_i.log_q.size());
    cmp_log(1, 1'b1, crt_pkg::CRT_PORT_OPERAND, 32'hD0D0_0000);
    cmp_log(2, 1'b1, crt_pkg::CRT_PORT_OPERAND, 32'hD0D0_000F);
    run(prim(1'b0, 1'b0, crt_pkg::PAT_MULTI_MAIN, 8'h00), 1'b1, 1'b0);
    cmp("violation", 35'h1, pv_d);
    sel_data <= 32'h0000_0102;
    op_data <= 32'h5A5A_0001;
    run(prim(1'b1, 1'b1, crt_pkg::PAT_MULTI_MAIN, 8'h00), 1'b0, 1'b1);
    cmp("register order", 35'h18, rf_log);
    cmp("register data", op_data, rf_dat);
  endtask

  task t_cop;
    run(prim(1'b1, 1'b0, crt_pkg::PAT_MULTI_COP, 8'h04), 1'b1, 1'b0);
    cmp("violation", 35'h1, pv_d);
    run(prim(1'b1, 1'b0, crt_pkg::PAT_MULTI_COP, 8'h03), 1'b0, 1'b0);
    cmp("violation", 35'h1, pv_d);
    @(posedge ref_clk);
    scan_pc_load <= 1'b1;
    ea_mode <= crt_pkg::CRT_EA_OTHER;
    ea_ext_words <= 3'h2;
    @(posedge ref_clk);
    scan_pc_load <= 1'b0;
    run(prim(1'b1, 1'b0, crt_pkg::PAT_MULTI_COP, 8'h04), 1'b0, 1'b1);
    cmp("emulator", 35'h1, fl_d);
    cmp_log(0, 1'b1, crt_pkg::CRT_PORT_CONTROL, crt_pkg::ABORT_MASK);
    cmp("scan counter", 32'h0000_1004, scan_program_counter);
    ea_mode <= crt_pkg::CRT_EA_CONTROL;
    ea_ext_words <= 3'h0;
    sel_data <= 32'h0000_0081;
    run(prim(1'b1, 1'b0, crt_pkg::PAT_MULTI_COP, 8'h08), 1'b0, 1'b0);
    cmp("log size", 35'h5, crt_cop_model_i.log_q.size());
    cmp_log(4, 1'b1, crt_pkg::CRT_PORT_OPERAND, 32'h200C_0000);
    ea_mode <= crt_pkg::CRT_EA_PREDEC;
    run(prim(1'b1, 1'b1, crt_pkg::PAT_MULTI_COP, 8'h04), 1'b0, 1'b1);
    cmp("last address", 35'h1FF8, mem_last);
  endtask

  task t_stat;
    run(prim(1'b1, 1'b0, {crt_pkg::PAT_STAT_SCAN, 1'b0}, 8'h00), 1'b1, 1'b0);
    cmp("violation", 35'h1, pv_d);
    run(prim(1'b1, 1'b0, {crt_pkg::PAT_STAT_SCAN, 1'b0}, 8'h00), 1'b0, 1'b0);
    cmp_log(0, 1'b1, crt_pkg::CRT_PORT_OPERAND, {16'h0000, crt_pkg::SR_RESET});
    run(prim(1'b1, 1'b0, {crt_pkg::PAT_STAT_SCAN, 1'b1}, 8'h00), 1'b0, 1'b1);
    cmp_log(0, 1'b1, crt_pkg::CRT_PORT_INSTADDR, 32'h0000_1004);
    cmp_log(1, 1'b1, crt_pkg::CRT_PORT_OPERAND, {16'h0000, crt_pkg::SR_RESET});
    op_data <= 32'h0000_4715;
    run(prim(1'b1, 1'b1, {crt_pkg::PAT_STAT_SCAN, 1'b0}, 8'h00), 1'b0, 1'b1);
    cmp("status in", 35'h4715, status_word);
    cmp("flush", 35'h1, pf_d);
    instr_start <= 1'b1;
    op_data <= 32'h0000_2715;
    @(posedge ref_clk);
    instr_start <= 1'b0;
    run(prim(1'b1, 1'b1, {crt_pkg::PAT_STAT_SCAN, 1'b1}, 8'h00), 1'b0, 1'b0);
    cmp("status in", 35'h2715, status_word);
    cmp("scan counter", 35'h00FF_2715, scan_program_counter);
    cmp("supervisor refill", 35'h1, pipe_refill_super);
    cmp("trace early", 35'h0, tr_n);
    cop_done <= 1'b1;
    @(posedge ref_clk);
    cop_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp("trace", 35'h1, tr_n);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    prim_valid = 1'b0;
    prim_word = 16'h0000;
    cond_category = 1'b0;
    instr_start = 1'b0;
    cop_done = 1'b0;
    ea_mode = crt_pkg::CRT_EA_CONTROL;
    ea_addr = 32'h0000_2000;
    ea_ext_words = 3'h0;
    ea_areg = 3'h0;
    scan_pc_init = 32'h0000_1000;
    scan_pc_load = 1'b0;
    slow = 1'b0;
    sel_data = 32'h0000_0000;
    op_data = 32'h0000_0000;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    cmp("status reset", crt_pkg::SR_RESET, status_word);
    t_ctrl_bad;
    t_ctrl(1'b0);
    t_ctrl(1'b1);
    t_main;
    t_cop;
    t_stat;
    end_sim;
  end

  // The whole run needs a few hundred cycles; this limit is far beyond that.
  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
endmodule

// ---- dv/crt_cop_model.sv ----
`timescale 1ns/1ps
// Coprocessor side of the port registers: answers each port request with a one-cycle
// acknowledge, promptly or after three wait cycles, and logs every transfer in order.
module crt_cop_model (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                slow,
  input  wire logic [31:0]         sel_data,
  input  wire logic [31:0]         op_data,
  input  wire logic                port_req,
  input  wire logic                port_wr,
  input  wire crt_pkg::crt_port_e  port_sel,
  input  wire logic [31:0]         port_wdata,
  output logic                     port_ack,
  output logic [31:0]              port_rdata,
  input  wire logic                mem_req,
  input  wire logic [31:0]         mem_addr,
  output logic                     mem_ack,
  output logic [31:0]              mem_rdata
);
  logic [1:0]  wait_r;
  logic [31:0] last_r;
  logic [34:0] log_q[$];

  // ---------------------------------------------------------------------------
  // Acknowledge and log
  // ---------------------------------------------------------------------------
  // A fresh request is never acknowledged in the cycle right after an acknowledge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      port_ack <= 1'b0;
      wait_r   <= 2'h0;
    end else if (port_ack) begin
      port_ack <= 1'b0;
      wait_r   <= 2'h0;
      last_r   <= port_rdata;
    end else if (port_req && wait_r >= (slow ? 2'h3 : 2'h0)) begin
      port_ack <= 1'b1;
      log_q.push_back({port_wr, port_sel, port_wr ? port_wdata : 32'h0000_0000});
    end else if (port_req) begin
      wait_r <= wait_r + 2'h1;
    end
  end

  // Read data is valid only with the acknowledge; otherwise the lines show garbage.
  always_comb begin
    port_rdata = ~last_r;
    if (port_ack) begin
      case (port_sel)
        crt_pkg::CRT_PORT_SELECT:   port_rdata = sel_data;
        crt_pkg::CRT_PORT_OPERAND:  port_rdata = op_data;
        crt_pkg::CRT_PORT_INSTADDR: port_rdata = op_data ^ 32'h00FF_0000;
        default:                    port_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Memory answers in the same cycle as the paired port beat.
  assign mem_ack   = mem_req & port_ack;
  assign mem_rdata = {mem_addr[15:0], mem_addr[31:16]};
endmodule

// ---- verilog/crt_core.sv ----
`timescale 1ns/1ps
// Summary of operation
// - An invalid control register select code raises a protocol violation.
// - Valid code: direction 1 writes control register, 0 reads it, one long word.
// - Multi main register primitive: flags 15..13, pattern 00110, low byte zero.
// - Multi main primitive with come-again clear in conditional raises violation.
// - Read 16-bit mask; move data regs 7..0 then address regs 7..0.
// - Mask bits 15..8 are address regs 7..0, bits 7..0 data regs.
// - Direction picks write or read per register, same order both ways.
// - Multi coprocessor primitive moves 0..16 operands, illegal in conditional.
// - Multi coprocessor word: flags 15..13, pattern 00001, length in low byte.
// - Odd operand length raises a protocol violation.
// - Compute effective address; scan counter advances two per extension word.
// - Illegal addressing mode writes abort mask and takes emulator exception.
// - Read mask after address; operand count is number of set bits.
// - Direction 1 stores operands to memory, direction 0 fetches to port.
// - Control and postincrement ascend; postincrement adds total byte count.
// - Predecrement descends per operand, bytes ascend, register drops total.
// - Status/scan primitive in conditional raises a protocol violation.
// - Scan option 0 moves the 16-bit status word either way.
// - Scan option 1, direction 0: scan counter out, then status word.
// - Scan option 1, direction 1: status word in, then scan counter.
// - Direction 1 flushes prefetch and refills from scan counter, in S space only if status bit 13 is set.
// - Trace-on-flow at start with direction 1 traces after completion.
// - Control register primitive first reads its select code.
module crt_core (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Primitive from the response port and instruction context.
  input  wire logic        prim_valid,
  input  wire logic [15:0] prim_word,
  input  wire logic        cond_category,
  input  wire logic        instr_start,
  input  wire logic        cop_done,
  // Effective address unit.
  output logic             ea_req,
  input  wire logic        ea_done,
  input  wire crt_pkg::crt_ea_e ea_mode,
  input  wire logic [31:0] ea_addr,
  input  wire logic [2:0]  ea_ext_words,
  input  wire logic [2:0]  ea_areg,
  // Coprocessor port register access.
  output logic             port_req,
  output logic             port_wr,
  output crt_pkg::crt_port_e port_sel,
  output logic [31:0]      port_wdata,
  input  wire logic        port_ack,
  input  wire logic [31:0] port_rdata,
  // Memory access, long word per beat.
  output logic             mem_req,
  output logic             mem_wr,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Register file and control register file access.
  output logic             rf_we,
  output logic [3:0]       rf_idx,
  output logic [31:0]      rf_wdata,
  input  wire logic [31:0] rf_rdata,
  output logic             cr_we,
  output logic [11:0]      cr_sel,
  output logic [31:0]      cr_wdata,
  input  wire logic [31:0] cr_rdata,
  // Processor state and outcomes.
  output logic [15:0]      status_word,
  output logic [31:0]      scan_program_counter,
  input  wire logic [31:0] scan_pc_init,
  input  wire logic        scan_pc_load,
  output logic             pipe_flush,
  output logic             pipe_refill_super,
  output logic             proto_violation,
  output logic             fline_exception,
  output logic             trace_exception,
  output logic             busy
);

  typedef enum {S_IDLE, S_SEL, S_CR, S_MASK, S_MAIN, S_EA, S_ABORT, S_COP_MASK,
                S_COP_PORT, S_COP_MEM, S_SS_A, S_SS_B, S_DONE} crt_state_e;

  crt_state_e  st_r;
  logic [15:0] pw_r;
  logic [15:0] mask_r;
  logic [11:0] code_r;
  logic [4:0]  cnt_r;
  logic [7:0]  bleft_r;
  logic [31:0] addr_r;
  logic [31:0] opbase_r;
  logic        trace_arm_r;
  logic        trace_pend_r;

  // Decodes a valid control register select code.
  function automatic logic code_ok(input logic [11:0] c);
    code_ok = (c == crt_pkg::SEL_SRC_FC) || (c == crt_pkg::SEL_DST_FC) ||
              (c == crt_pkg::SEL_CACHE_CT) || (c == crt_pkg::SEL_USER_SP) ||
              (c == crt_pkg::SEL_VEC_BASE) || (c == crt_pkg::SEL_CACHE_AD) ||
              (c == crt_pkg::SEL_MAST_SP) || (c == crt_pkg::SEL_INT_SP);
  endfunction

  // Counts set bits of a select mask.
  function automatic logic [4:0] ones(input logic [15:0] m);
    ones = 5'h00;
    for (int i = 0; i < 16; i++) begin
      ones = ones + {4'h0, m[i]};
    end
  endfunction

  // Picks the next register in order DATA_REGS_SEVEN_TO_ZERO then ADDR_REGS_SEVEN_TO_ZERO and returns its index.
  function automatic logic [3:0] next_reg(input logic [15:0] m);
    next_reg = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        next_reg = 4'(i ^ 8);
      end
    end
  endfunction

  wire logic        dir    = pw_r[crt_pkg::DIRECTION_BIT];
  wire logic        scan_o = pw_r[crt_pkg::SCAN_OPT_BIT];
  wire logic [15:0] m_ord  = {mask_r[7:0], mask_r[15:8]};
  wire logic [3:0]  cur_rg = next_reg(m_ord);
  wire logic        is_pre = (ea_mode == crt_pkg::CRT_EA_PREDEC);
  wire logic [4:0]  p_hi   = prim_word[12:8];
  wire logic        mode_ok = dir ?
    (ea_mode == crt_pkg::CRT_EA_CTRL_ALT || ea_mode == crt_pkg::CRT_EA_PREDEC) :
    (ea_mode == crt_pkg::CRT_EA_CONTROL || ea_mode == crt_pkg::CRT_EA_CTRL_ALT ||
     ea_mode == crt_pkg::CRT_EA_POSTINC);

  // Primitive sequencer.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r     <= S_IDLE;
      pw_r     <= 16'h0000;
      mask_r   <= 16'h0000;
      code_r   <= 12'h000;
      cnt_r    <= 5'h00;
      bleft_r  <= 8'h00;
      addr_r   <= 32'h0000_0000;
      opbase_r <= 32'h0000_0000;
    end else begin
      unique case (st_r)
        S_IDLE: if (prim_valid) begin
          pw_r <= prim_word;
          if (p_hi == crt_pkg::PAT_CTRL_REG && prim_word[7:0] == 8'h00) begin
            st_r <= S_SEL;
          end else if (p_hi == crt_pkg::PAT_MULTI_MAIN && prim_word[7:0] == 8'h00) begin
            st_r <= (cond_category && !prim_word[crt_pkg::COME_AGAIN_BIT]) ?
                    S_DONE : S_MASK;
          end else if (p_hi == crt_pkg::PAT_MULTI_COP) begin
            st_r <= (cond_category || prim_word[0]) ? S_DONE : S_EA;
          end else if (prim_word[12:9] == crt_pkg::PAT_STAT_SCAN) begin
            st_r <= cond_category ? S_DONE : S_SS_A;
          end else begin
            st_r <= S_DONE;
          end
        end
        S_SEL: if (port_ack) begin
          code_r <= port_rdata[11:0];
          st_r   <= code_ok(port_rdata[11:0]) ? S_CR : S_DONE;
        end
        S_CR: if (port_ack) begin
          st_r <= S_DONE;
        end
        S_MASK: if (port_ack) begin
          mask_r <= port_rdata[15:0];
          st_r   <= S_MAIN;
        end
        S_MAIN: if (mask_r == 16'h0000) begin
          st_r <= S_DONE;
        end else if (port_ack) begin
          mask_r[cur_rg] <= 1'b0;
        end
        S_EA: if (ea_done) begin
          st_r     <= mode_ok ? S_COP_MASK : S_ABORT;
          addr_r   <= ea_addr;
          opbase_r <= ea_addr;
        end
        S_ABORT: if (port_ack) begin
          st_r <= S_DONE;
        end
        S_COP_MASK: if (port_ack) begin
          cnt_r <= ones(port_rdata[15:0]);
          st_r  <= S_COP_PORT;
        end
        S_COP_PORT: if (cnt_r == 5'h00 || pw_r[7:0] == 8'h00) begin
          st_r <= S_DONE;
        end else begin
          bleft_r <= pw_r[7:0];
          if (is_pre) begin
            addr_r   <= opbase_r - {24'h00_0000, pw_r[7:0]};
            opbase_r <= opbase_r - {24'h00_0000, pw_r[7:0]};
          end
          st_r <= S_COP_MEM;
        end
        S_COP_MEM: if (port_ack && mem_ack) begin
          if (bleft_r <= 8'h04) begin
            cnt_r <= cnt_r - 5'h01;
            st_r  <= S_COP_PORT;
            if (!is_pre) begin
              opbase_r <= opbase_r + {24'h00_0000, pw_r[7:0]};
            end
          end else begin
            bleft_r <= bleft_r - 8'h04;
          end
          addr_r <= addr_r + 32'h0000_0004;
        end
        S_SS_A: if (port_ack) begin
          st_r <= scan_o ? S_SS_B : S_DONE;
        end
        S_SS_B: if (port_ack) begin
          st_r <= S_DONE;
        end
        S_DONE: st_r <= S_IDLE;
      endcase
    end
  end

  // Exception outcomes, one-cycle pulses on leaving a sequence.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      proto_violation <= 1'b0;
      fline_exception <= 1'b0;
    end else begin
      proto_violation <= st_r == S_IDLE && prim_valid &&
        ((p_hi == crt_pkg::PAT_MULTI_MAIN && cond_category &&
          !prim_word[crt_pkg::COME_AGAIN_BIT]) ||
         (p_hi == crt_pkg::PAT_MULTI_COP && (cond_category || prim_word[0])) ||
         (prim_word[12:9] == crt_pkg::PAT_STAT_SCAN && cond_category)) ||
        (st_r == S_SEL && port_ack && !code_ok(port_rdata[11:0]));
      fline_exception <= st_r == S_ABORT && port_ack;
    end
  end

  // Status word, scan counter, pipe refill and trace arming.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_word          <= crt_pkg::SR_RESET;
      scan_program_counter <= 32'h0000_0000;
      pipe_flush           <= 1'b0;
      pipe_refill_super    <= 1'b0;
      trace_arm_r          <= 1'b0;
      trace_pend_r         <= 1'b0;
      trace_exception      <= 1'b0;
    end else begin
      pipe_flush      <= 1'b0;
      trace_exception <= 1'b0;
      if (instr_start) begin
        trace_arm_r  <= status_word[15:14] == crt_pkg::TRACE_ON_FLOW;
        trace_pend_r <= 1'b0;
      end
      if (scan_pc_load) begin
        scan_program_counter <= scan_pc_init;
      end else if (st_r == S_EA && ea_done) begin
        scan_program_counter <= scan_program_counter + {28'h000_0000, ea_ext_words, 1'b0};
      end
      if (dir && port_ack && ((st_r == S_SS_A) || (st_r == S_SS_B && !scan_o))) begin
        status_word <= port_rdata[15:0];
      end
      if (dir && port_ack && st_r == S_SS_B) begin
        scan_program_counter <= port_rdata;
      end
      if (st_r == S_DONE && dir && pw_r[12:9] == crt_pkg::PAT_STAT_SCAN &&
          !proto_violation) begin
        pipe_flush        <= 1'b1;
        pipe_refill_super <= status_word[13];
        if (trace_arm_r) begin
          trace_pend_r <= 1'b1;
        end
      end
      if (trace_pend_r && cop_done) begin
        trace_exception <= 1'b1;
        trace_pend_r    <= 1'b0;
      end
    end
  end

  // Port, memory and register file requests for the current step.
  always_comb begin
    port_req   = 1'b0;
    port_wr    = 1'b0;
    port_sel   = crt_pkg::CRT_PORT_OPERAND;
    port_wdata = 32'h0000_0000;
    mem_req    = 1'b0;
    mem_wr     = dir;
    mem_addr   = addr_r;
    mem_wdata  = port_rdata;
    rf_we      = 1'b0;
    rf_idx     = cur_rg;
    rf_wdata   = port_rdata;
    cr_we      = 1'b0;
    cr_sel     = code_r;
    cr_wdata   = port_rdata;
    ea_req     = st_r == S_EA;
    unique case (st_r)
      S_SEL, S_MASK, S_COP_MASK: begin
        port_req = 1'b1;
        port_sel = crt_pkg::CRT_PORT_SELECT;
      end
      S_CR: begin
        port_req   = 1'b1;
        port_wr    = !dir;
        port_wdata = cr_rdata;
        cr_we      = dir && port_ack;
      end
      S_MAIN: begin
        port_req   = mask_r != 16'h0000;
        port_wr    = !dir;
        port_wdata = rf_rdata;
        rf_we      = dir && port_ack && mask_r != 16'h0000;
      end
      S_ABORT: begin
        port_req   = 1'b1;
        port_wr    = 1'b1;
        port_sel   = crt_pkg::CRT_PORT_CONTROL;
        port_wdata = crt_pkg::ABORT_MASK;
      end
      S_COP_MEM: begin
        port_req   = 1'b1;
        port_wr    = !dir;
        port_wdata = mem_rdata;
        mem_req    = 1'b1;
      end
      S_SS_A: begin
        port_req   = 1'b1;
        port_wr    = !dir;
        port_sel   = (scan_o && !dir) ? crt_pkg::CRT_PORT_INSTADDR : crt_pkg::CRT_PORT_OPERAND;
        port_wdata = (scan_o && !dir) ? scan_program_counter : {16'h0000, status_word};
      end
      S_SS_B: begin
        port_req   = 1'b1;
        port_wr    = !dir;
        port_sel   = dir ? crt_pkg::CRT_PORT_INSTADDR : crt_pkg::CRT_PORT_OPERAND;
        port_wdata = {16'h0000, status_word};
      end
      default: begin
      end
    endcase
  end

  assign busy = st_r != S_IDLE;

  // Guards on the sequencer and its outcomes.

  ctrl_seq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_SEL && port_ack && !code_ok(port_rdata[11:0])) |=> proto_violation)
    else $error("invalid select code not flagged");
  abort_mode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_ABORT) |-> (port_sel == crt_pkg::CRT_PORT_CONTROL && port_wr))
    else $error("abort mask not written to control port");
  main_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_MAIN && port_ack && mask_r != 16'h0000) |=> !mask_r[$past(cur_rg)])
    else $error("selected register not retired");
  cond_cop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_IDLE && prim_valid && cond_category && p_hi == crt_pkg::PAT_MULTI_COP)
    |=> proto_violation ##1 st_r == S_IDLE)
    else $error("conditional multi coprocessor not refused");
  flush_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pipe_flush |-> $past(dir))
    else $error("flush without inbound direction");
  trace_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trace_exception |-> $past(trace_pend_r) && $past(cop_done))
    else $error("trace taken without completion");
  scan_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_SS_A && scan_o && !dir) |-> port_sel == crt_pkg::CRT_PORT_INSTADDR)
    else $error("scan counter not sent first");
  ss_cond_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == S_IDLE && prim_valid && cond_category && prim_word[12:9] == crt_pkg::PAT_STAT_SCAN)
    |=> st_r == S_DONE)
    else $error("conditional status transfer not refused");

endmodule

// ---- verilog/crt_pkg.sv ----
package crt_pkg;

  // ---------------------------------------------------------------------------
  // Primitive word layout
  // ---------------------------------------------------------------------------
  localparam int          COME_AGAIN_BIT = 15;
  localparam int          PC_PASS_BIT    = 14;
  localparam int          DIRECTION_BIT  = 13;
  localparam int          SCAN_OPT_BIT   = 8;
  localparam logic [4:0]  PAT_MULTI_MAIN = 5'h06;
  localparam logic [4:0]  PAT_MULTI_COP  = 5'h01;
  localparam logic [4:0]  PAT_CTRL_REG   = 5'h0d;
  localparam logic [3:0]  PAT_STAT_SCAN  = 4'h1;

  // ---------------------------------------------------------------------------
  // Control register select codes (low 12 bits)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] SEL_SRC_FC   = 12'h000;
  localparam logic [11:0] SEL_DST_FC   = 12'h001;
  localparam logic [11:0] SEL_CACHE_CT = 12'h002;
  localparam logic [11:0] SEL_USER_SP  = 12'h800;
  localparam logic [11:0] SEL_VEC_BASE = 12'h801;
  localparam logic [11:0] SEL_CACHE_AD = 12'h802;
  localparam logic [11:0] SEL_MAST_SP  = 12'h803;
  localparam logic [11:0] SEL_INT_SP   = 12'h804;

  // ---------------------------------------------------------------------------
  // Port register selectors, modes and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {CRT_PORT_OPERAND, CRT_PORT_SELECT, CRT_PORT_INSTADDR,
                            CRT_PORT_CONTROL} crt_port_e;
  typedef enum logic [2:0] {CRT_EA_CONTROL, CRT_EA_CTRL_ALT, CRT_EA_POSTINC,
                            CRT_EA_PREDEC, CRT_EA_OTHER} crt_ea_e;
  localparam logic [31:0] ABORT_MASK    = 32'h0000_0002;
  localparam logic [15:0] SR_RESET      = 16'h2700;
  localparam logic [1:0]  TRACE_ON_FLOW = 2'h1;
  localparam logic [4:0]  MAX_OPERANDS  = 5'h10;

endpackage
